/* lmi_pkg.sv */
package lmi_pkg;

    // opcode widths and fixed patterns (14-bit instruction word)
    localparam int          INSN_W         = 14;
    localparam logic [13:0] OP_NOP         = 14'h0000;
    localparam logic [13:0] OP_RESET       = 14'h0001;
    localparam logic [13:0] OP_OPTION      = 14'h0062;
    localparam logic [6:0]  OP_STORE_WF_HI = 7'h01;   // 00_0000_1fff_ffff
    localparam logic [10:0] OP_STORE_WI_HI = 11'h003; // 00_0000_0001_1nmm
    localparam logic [6:0]  OP_STORE_WIK   = 7'h7f;   // 11_1111_1nkk_kkkk
    localparam logic [8:0]  OP_BANK_HI     = 9'h001;  // 00_0000_001k_kkkk
    localparam logic [6:0]  OP_PAGE_HI     = 7'h63;   // 11_0001_1kkk_kkkk
    localparam logic [3:0]  OP_WORK_HI     = 4'hc;    // 11_00xx_kkkk_kkkk

    // index mode field encodings
    localparam logic [1:0]  MODE_PREINC    = 2'h0;
    localparam logic [1:0]  MODE_PREDEC    = 2'h1;
    localparam logic [1:0]  MODE_POSTINC   = 2'h2;
    localparam logic [1:0]  MODE_POSTDEC   = 2'h3;

    // values after reset
    localparam logic [7:0]  RST_WORK       = 8'h00;
    localparam logic [4:0]  RST_BANK       = 5'h00;
    localparam logic [6:0]  RST_PAGE       = 7'h00;
    localparam logic [7:0]  RST_TIMER_CFG  = 8'hff;
    localparam logic [15:0] RST_POINTER    = 16'h0000;
    localparam logic [15:0] PTR_ONE        = 16'h0001;

    // one write to the data space
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } lmi_wr_t;

    // whole state of the executer
    typedef struct packed {
        logic [7:0]  work;
        logic [4:0]  bankSel;
        logic [6:0]  pcHigh;
        logic [7:0]  timerCfg;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        lmi_wr_t     wr;
        logic        swReset;
        logic        resetInsnFlagClr;
        logic        done;
    } lmi_state_t;

endpackage

/* lmi_exec.sv */
`timescale 1ns/1ps
// Overview of operation
// - bank literal load puts 5-bit immediate into bank select, flags untouched
// - page literal load puts 7-bit immediate into pc high latch, flags untouched
// - work literal load puts 8-bit immediate into working register, flags untouched
// - store work to file writes working register at 7-bit bank address
// - indirect store writes working register via chosen pointer, updating it
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - offset form addresses pointer plus signed -32..31, pointer unchanged
// - pointers are 16 bits and wrap on both ends
// - indirect store and pointer update change no status flag
// - indirect port has no storage; accesses go to pointer address
// - timer configuration load copies working register, flags untouched
// - software reset requests device reset and clears reset-instruction flag
module lmi_exec
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // instruction issue from the core, same clock
    input  wire logic                 insnValid,
    input  wire logic [13:0]          insnWord,
    // data space write, 16-bit linear address
    output lmi_pkg::lmi_wr_t          dataWr,
    // architectural registers
    output logic [7:0]                workReg,
    output logic [4:0]                bankSelectReg,
    output logic [6:0]                pcHighLatch,
    output logic [7:0]                timerCfgReg,
    output logic [15:0]               filePointer0,
    output logic [15:0]               filePointer1,
    // reset control and retirement
    output logic                      swResetReq,
    output logic                      resetInstructionFlagClr,
    output logic                      insnDone
);
    import lmi_pkg::*;

    lmi_state_t stateQ;
    lmi_state_t stateD;

    // decode and next-state; status flags are not touched by any path here
    always_comb
    begin
        logic [15:0] ptrSel;
        logic [15:0] ptrNew;
        logic [15:0] offs;
        logic [1:0]  mode;
        logic        ptrN;
        ptrSel = 16'h0000;
        ptrNew = 16'h0000;
        offs   = 16'h0000;
        mode   = 2'h0;
        ptrN   = 1'b0;
        stateD = stateQ;
        stateD.wr.valid         = 1'b0;
        stateD.swReset          = 1'b0;
        stateD.resetInsnFlagClr = 1'b0;
        stateD.done             = insnValid;
        if (insnValid)
        begin
            if (insnWord == OP_NOP)
            begin
                stateD.done = 1'b1;
            end
            else if (insnWord == OP_RESET)
            begin
                stateD.swReset          = 1'b1;
                stateD.resetInsnFlagClr = 1'b1;
            end
            else if (insnWord == OP_OPTION)
            begin
                stateD.timerCfg = stateQ.work;
            end
            else if (insnWord[13:7] == OP_STORE_WF_HI)
            begin
                stateD.wr.valid = 1'b1;
                stateD.wr.addr  = {4'h0, stateQ.bankSel, insnWord[6:0]};
                stateD.wr.data  = stateQ.work;
            end
            else if (insnWord[13:3] == OP_STORE_WI_HI)
            begin
                ptrN   = insnWord[2];
                mode   = insnWord[1:0];
                ptrSel = ptrN ? stateQ.ptr1 : stateQ.ptr0;
                // 16-bit arithmetic wraps naturally
                if (mode == MODE_PREINC || mode == MODE_POSTINC)
                    ptrNew = ptrSel + PTR_ONE;
                else
                    ptrNew = ptrSel - PTR_ONE;
                stateD.wr.valid = 1'b1;
                stateD.wr.data  = stateQ.work;
                // pre modes write at new value, post modes at old value
                case (mode)
                    MODE_PREINC:  stateD.wr.addr = ptrNew;
                    MODE_PREDEC:  stateD.wr.addr = ptrNew;
                    MODE_POSTINC: stateD.wr.addr = ptrSel;
                    MODE_POSTDEC: stateD.wr.addr = ptrSel;
                    default:      stateD.wr.addr = ptrSel;
                endcase
                if (ptrN)
                    stateD.ptr1 = ptrNew;
                else
                    stateD.ptr0 = ptrNew;
            end
            else if (insnWord[13:7] == OP_STORE_WIK)
            begin
                ptrSel = insnWord[6] ? stateQ.ptr1 : stateQ.ptr0;
                offs   = {{10{insnWord[5]}}, insnWord[5:0]};
                stateD.wr.valid = 1'b1;
                stateD.wr.addr  = ptrSel + offs;
                stateD.wr.data  = stateQ.work;
            end
            else if (insnWord[13:5] == OP_BANK_HI)
            begin
                stateD.bankSel = insnWord[4:0];
            end
            else if (insnWord[13:7] == OP_PAGE_HI)
            begin
                stateD.pcHigh = insnWord[6:0];
            end
            else if (insnWord[13:10] == OP_WORK_HI)
            begin
                stateD.work = insnWord[7:0];
            end
            else
            begin
                stateD.done = 1'b0; // not in this group
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateQ.work             <= RST_WORK;
            stateQ.bankSel          <= RST_BANK;
            stateQ.pcHigh           <= RST_PAGE;
            stateQ.timerCfg         <= RST_TIMER_CFG;
            stateQ.ptr0             <= RST_POINTER;
            stateQ.ptr1             <= RST_POINTER;
            stateQ.wr               <= '0;
            stateQ.swReset          <= 1'b0;
            stateQ.resetInsnFlagClr <= 1'b0;
            stateQ.done             <= 1'b0;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // outputs straight from the state flops
    assign dataWr                  = stateQ.wr;
    assign workReg                 = stateQ.work;
    assign bankSelectReg           = stateQ.bankSel;
    assign pcHighLatch             = stateQ.pcHigh;
    assign timerCfgReg             = stateQ.timerCfg;
    assign filePointer0            = stateQ.ptr0;
    assign filePointer1            = stateQ.ptr1;
    assign swResetReq              = stateQ.swReset;
    assign resetInstructionFlagClr = stateQ.resetInsnFlagClr;
    assign insnDone                = stateQ.done;

endmodule // lmi_exec

/* lmi_exec_chk.sv */
`timescale 1ns/1ps
module lmi_exec_chk
(
    // clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // instruction issue
    input wire logic             insnValid,
    input wire logic [13:0]      insnWord,
    // watched outputs
    input wire lmi_pkg::lmi_wr_t dataWr,
    input wire logic [7:0]       workReg,
    input wire logic [4:0]       bankSelectReg,
    input wire logic [6:0]       pcHighLatch,
    input wire logic [7:0]       timerCfgReg,
    input wire logic [15:0]      filePointer0,
    input wire logic [15:0]      filePointer1,
    input wire logic             swResetReq,
    input wire logic             resetInstructionFlagClr,
    input wire logic             insnDone
);
    import lmi_pkg::*;
    // sign-extended offset of the offset form
    logic [15:0] offs;
    assign offs = {{10{insnWord[5]}}, insnWord[5:0]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // each taken word shows its effect one edge later
    bank_load_a: assert property (insnValid && insnWord[13:5] == 9'h001 |=>
        bankSelectReg == $past(insnWord[4:0]) && insnDone) else $error("bank load");
    page_load_a: assert property (insnValid && insnWord[13:7] == 7'h63 |=>
        pcHighLatch == $past(insnWord[6:0])) else $error("page load");
    work_load_a: assert property (insnValid && insnWord[13:10] == 4'hc |=>
        workReg == $past(insnWord[7:0]) && insnDone) else $error("work load");
    file_store_a: assert property (insnValid && insnWord[13:7] == 7'h01 |=> dataWr.valid
        && dataWr.addr == {4'h0, $past(bankSelectReg), $past(insnWord[6:0])}
        && dataWr.data == $past(workReg)) else $error("file store");
    timer_load_a: assert property (insnValid && insnWord == 14'h0062 |=>
        timerCfgReg == $past(workReg)) else $error("timer load");
    soft_reset_a: assert property (insnValid && insnWord == 14'h0001 |=>
        swResetReq && resetInstructionFlagClr) else $error("soft reset");
    pre_inc_a: assert property (insnValid && insnWord == 14'h0018 |=>
        filePointer0 == $past(filePointer0) + 16'h0001 && dataWr.valid
        && dataWr.addr == filePointer0) else $error("pre increment");
    offset_form_a: assert property (insnValid && insnWord[13:6] == 8'hfe |=>
        $stable(filePointer0) && dataWr.addr == $past(filePointer0) + $past(offs))
        else $error("offset form");
    // main scenarios reached
    cover property (insnValid && insnWord == 14'h0001);
    cover property (dataWr.valid && insnDone);
    cover property (insnValid && insnWord[13:6] == 8'hfe);
endmodule // lmi_exec_chk

bind lmi_exec lmi_exec_chk i_lmi_exec_chk (.clk, .reset_n, .insnValid, .insnWord, .dataWr,
    .workReg, .bankSelectReg, .pcHighLatch, .timerCfgReg, .filePointer0, .filePointer1,
    .swResetReq, .resetInstructionFlagClr, .insnDone);

/* literal_move_indirect_exec_bench.sv */
`timescale 1ns/1ps
module literal_move_indirect_exec_bench;
    import lmi_pkg::*;
    // stimulus and observed ports
    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          insnValid = 1'b0;
    logic [13:0]   insnWord = 14'h0000;
    lmi_wr_t       dataWr;
    logic [7:0]    workReg, timerCfgReg;
    logic [4:0]    bankSelectReg;
    logic [6:0]    pcHighLatch;
    logic [15:0]   filePointer0, filePointer1;
    logic          swResetReq, resetInstructionFlagClr, insnDone;
    int            fails = 0;
    int            checked = 0;
    // block under test
    lmi_exec i_lmi_exec (.clk, .reset_n, .insnValid, .insnWord, .dataWr, .workReg,
        .bankSelectReg, .pcHighLatch, .timerCfgReg, .filePointer0, .filePointer1,
        .swResetReq, .resetInstructionFlagClr, .insnDone);
    // 100 MHz clock
    initial forever #5 clk = ~clk;
    // compare and count
    task automatic ck(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    // one word taken, result settled on return
    task automatic run(input logic [13:0] w);
        @(posedge clk);
        insnValid <= 1'b1;
        insnWord  <= w;
        @(posedge clk);
        insnValid <= 1'b0;
        #1;
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // literal loads at top of range
    task automatic t_lit();
        run(14'h30ff);
        ck("work", 16'(workReg), 16'h00ff);
        ck("done", 16'(insnDone), 16'h0001);
        run(14'h003f);
        ck("bank", 16'(bankSelectReg), 16'h001f);
        run(14'h31ff);
        ck("page", 16'(pcHighLatch), 16'h007f);
    endtask
    // back-to-back literal, file store, timer load
    task automatic t_store();
        @(posedge clk);
        insnValid <= 1'b1;
        insnWord  <= 14'h304f;
        @(posedge clk);
        insnWord  <= 14'h00ff;
        run(14'h0062);
        ck("faddr", dataWr.addr, 16'h0fff);
        ck("fdata", 16'(dataWr.data), 16'h004f);
        ck("timer", 16'(timerCfgReg), 16'h004f);
    endtask
    // all index modes, wrap and offsets
    task automatic t_ind();
        run(14'h0019);
        ck("pdec", filePointer0, 16'hffff);
        ck("pdeca", dataWr.addr, 16'hffff);
        run(14'h0018);
        ck("pinc", filePointer0, 16'h0000);
        run(14'h001e);
        ck("qinca", dataWr.addr, 16'h0000);
        ck("qinc", filePointer1, 16'h0001);
        run(14'h001f);
        ck("qdeca", dataWr.addr, 16'h0001);
        ck("qdec", filePointer1, 16'h0000);
        run(14'h3fe0);
        ck("offn", dataWr.addr, 16'hffe0);
        run(14'h3f9f);
        ck("offp", dataWr.addr, 16'h001f);
        ck("offk", filePointer0, 16'h0000);
    endtask
    // no-op, foreign word, software reset
    task automatic t_misc();
        run(14'h0000);
        ck("nopw", 16'(dataWr.valid), 16'h0000);
        ck("nopd", 16'(insnDone), 16'h0001);
        run(14'h0008);
        ck("other", 16'(insnDone), 16'h0000);
        run(14'h0001);
        ck("swrst", {15'h0, swResetReq & resetInstructionFlagClr}, 16'h0001);
    endtask
    // hang guard
    initial
    begin
        repeat (2000) @(posedge clk);
        fails++;
        close_out();
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        ck("rtimer", 16'(timerCfgReg), 16'h00ff);
        t_lit();
        t_store();
        t_ind();
        t_misc();
        close_out();
    end
endmodule // literal_move_indirect_exec_bench
